// >>> pcc_ctrl.sv
// Pulse output command controller with AHB-Lite register slave
//
// The AHB-Lite interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps
// Contract
// - Feed runs speed, marker switches to positioning
// - Stop code 0003 halts output at once
// - Absolute target picks direction from present value
// - Limit input stops output as configured
// - Configurable origin clear on limit input
// - Output frequency is clock over integer ratio
// - Division ratio rounded to nearest integer
// - Ramp rate applied per 4 ms step
// - Feed interrupt enable caught only at power-up
// - Refuse switching between counted and continuous
// - Reject unlisted combinations, stop always accepted
// - Counted speed takeover keeps pulse count
// - Continuous speed over continuous updates frequency
// - Counted ramp takeover keeps count, updates rates
// - Continuous ramp takeover updates target and rates
// - Positioning over ramp/positioning updates count too
// - Positioning over continuous ramp updates frequency, rates
// - Feed over feed only at 0 Hz
// - Limit stop sets error flag and code
module pcc_ctrl #(
  parameter logic [31:0] RAMP_CYCLES = 32'(pcc_pkg::RAMP_STEP_CYCLES)
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Sensor inputs
  input wire logic cw_limit,
  input wire logic ccw_limit,
  input wire logic interrupt_input_zero,
  input wire logic origin_in,
  input wire logic feed_irq_enable_strap,
  // Drive outputs
  output logic pulse_out,
  output logic dir_ccw,
  output logic busy
);
  import pcc_pkg::*;

  typedef struct packed {
    pcc_mode_e mode;
    logic has_ramp;
    logic stopping;
    logic feed_pos;
    logic dir;
    logic [31:0] cur_f;
    logic [31:0] tgt_f;
    logic [31:0] acc;
    logic [31:0] dec;
    logic [31:0] remaining;
    logic [31:0] ramp_cnt;
    logic [31:0] pv;
    logic [31:0] reg_freq;
    logic [31:0] reg_acc;
    logic [31:0] reg_dec;
    logic [31:0] reg_pulses;
    logic [1:0] cfg;
    logic done;
    logic cmd_err;
    logic stop_err;
    logic origin_ok;
    logic feed_en;
    logic caught;
    logic mark_prev;
    logic [15:0] err_code;
    logic wr_pend;
    logic rd_pend;
    logic [7:0] addr;
    logic [31:0] rdata;
  } pcc_state_s;

  pcc_state_s q, d;
  logic tick;

  // Nearest-integer division of the source clock
  function automatic logic [31:0] ratio_of(input logic [31:0] f);
    logic [31:0] r;
    r = ZERO32;
    if (f != ZERO32) begin
      r = (SRC_HZ + (f >> 1)) / f;
    end
    return r;
  endfunction : ratio_of

  // Pulses needed to ramp down from the present rate
  function automatic logic [31:0] brake_len(input logic [31:0] f, input logic [31:0] r);
    logic [63:0] num;
    logic [63:0] den;
    num = {32'h0, f} * {32'h0, f};
    den = {32'h0, r} * 64'(2 * RAMP_STEPS_PER_S);
    brake_len = (r == ZERO32) ? ZERO32 : 32'(num / den);
  endfunction : brake_len

  function automatic logic counted(input pcc_mode_e m, input logic fpos);
    return (m == M_SPD_IND) || (m == M_ACC_IND) || (m == M_POS) || (m == M_FEED && fpos);
  endfunction : counted

  // Allowed takeovers of a running operation
  function automatic logic cmd_ok(input pcc_mode_e m, input logic [2:0] k, input logic cont,
                                  input logic f_zero);
    logic ok;
    ok = 1'b0;
    unique case (m)
      M_IDLE: ok = 1'b1;
      M_SPD_IND: ok = !cont && (k == KIND_SPEED || k == KIND_RAMPED);
      M_SPD_CONT: ok = cont && (k == KIND_SPEED || k == KIND_RAMPED);
      M_ACC_IND: ok = (!cont && k == KIND_RAMPED) || k == KIND_POSITION;
      M_ACC_CONT: ok = (cont && k == KIND_RAMPED) || k == KIND_POSITION;
      M_POS: ok = (!cont && k == KIND_RAMPED) || k == KIND_POSITION;
      M_ORG: ok = 1'b0;
      M_FEED: ok = (k == KIND_FEED) && f_zero;
    endcase
    return ok;
  endfunction : cmd_ok

  pcc_pulse_gen u_gen (
    .hclk(hclk),
    .hresetn(hresetn),
    .ratio(ratio_of(q.cur_f)),
    .tick(tick),
    .pulse_out(pulse_out)
  );

  always_comb begin
    logic set_done;
    logic set_stop;
    logic [2:0] kind;
    logic cont;
    logic [31:0] cnt;
    logic ndir;
    logic [31:0] eff_t;
    logic [31:0] w;
    logic mark_rise;
    set_done = 1'b0;
    set_stop = 1'b0;
    kind = 3'h0;
    cont = 1'b0;
    cnt = ZERO32;
    ndir = 1'b0;
    eff_t = ZERO32;
    w = hwdata;
    mark_rise = interrupt_input_zero && !q.mark_prev;
    d = q;
    d.mark_prev = interrupt_input_zero;

    // Enable caught once after reset release; later changes need a new reset
    if (!q.caught) begin
      d.caught = 1'b1;
      d.feed_en = feed_irq_enable_strap;
    end

    // Motion
    if (q.mode != M_IDLE) begin
      if (tick) begin
        d.pv = q.dir ? q.pv - 32'h1 : q.pv + 32'h1;
        if (counted(q.mode, q.feed_pos)) begin
          d.remaining = q.remaining - 32'h1;
        end
      end
      if (counted(q.mode, q.feed_pos) && d.remaining == ZERO32) begin
        d.mode = M_IDLE;
        d.cur_f = ZERO32;
        set_done = (q.mode == M_POS) || (q.mode == M_FEED);
      end
      if (q.mode == M_ORG && origin_in) begin
        d.pv = ZERO32;
        d.origin_ok = 1'b1;
        d.mode = M_IDLE;
        d.cur_f = ZERO32;
      end
      if (q.mode == M_FEED && !q.feed_pos && q.feed_en && mark_rise) begin
        d.feed_pos = 1'b1;
      end
      // Ramp steps
      if (q.ramp_cnt >= RAMP_CYCLES - 32'h1) begin
        d.ramp_cnt = ZERO32;
      end else begin
        d.ramp_cnt = q.ramp_cnt + 32'h1;
      end
      eff_t = q.stopping ? ZERO32 : q.tgt_f;
      if (counted(q.mode, q.feed_pos) && q.has_ramp && q.remaining <= brake_len(q.cur_f, q.dec)) begin
        eff_t = (q.dec < q.tgt_f) ? q.dec : q.tgt_f;
      end
      if (!q.has_ramp) begin
        d.cur_f = eff_t;
      end else if (q.ramp_cnt >= RAMP_CYCLES - 32'h1) begin
        if (q.cur_f < eff_t) begin
          d.cur_f = (eff_t - q.cur_f > q.acc) ? q.cur_f + q.acc : eff_t;
        end else if (q.cur_f > eff_t) begin
          d.cur_f = (q.cur_f - eff_t > q.dec) ? q.cur_f - q.dec : eff_t;
        end
      end
      if (q.stopping && (q.cur_f == ZERO32 || q.dec == ZERO32)) begin
        d.mode = M_IDLE;
        d.cur_f = ZERO32;
        d.stopping = 1'b0;
      end
      if (cw_limit || ccw_limit) begin
        set_stop = 1'b1;
        d.err_code = cw_limit ? ERR_CW_LIMIT : ERR_CCW_LIMIT;
        if (q.cfg[CFG_LIM_CLR_ORG_BIT]) begin
          d.origin_ok = 1'b0;
        end
        if (q.cfg[CFG_LIM_DECEL_BIT] && q.has_ramp && q.dec != ZERO32) begin
          d.stopping = 1'b1;
        end else begin
          d.mode = M_IDLE;
          d.cur_f = ZERO32;
          d.stopping = 1'b0;
        end
      end
      if (d.mode == M_IDLE) begin
        d.cur_f = ZERO32;
      end
    end else begin
      d.ramp_cnt = ZERO32;
      d.feed_pos = 1'b0;
    end

    // Bus write data phase
    if (q.wr_pend) begin
      unique case (q.addr)
        FREQ_OFS: d.reg_freq = w;
        ACC_OFS: d.reg_acc = w;
        DEC_OFS: d.reg_dec = w;
        PULSES_OFS: d.reg_pulses = w;
        CFG_OFS: d.cfg = w[1:0];
        PV_OFS: d.pv = w;
        STATUS_OFS: begin
          d.done = q.done && !w[ST_DONE_BIT];
          d.cmd_err = q.cmd_err && !w[ST_CMD_ERR_BIT];
          d.stop_err = q.stop_err && !w[ST_STOP_ERR_BIT];
        end
        CMD_OFS: begin
          kind = w[CMD_KIND_LSB +: 3];
          cont = w[CMD_CONT_BIT];
          if (w[CMD_ABS_BIT]) begin
            ndir = $signed(q.reg_pulses) < $signed(q.pv);
            cnt = ndir ? q.pv - q.reg_pulses : q.reg_pulses - q.pv;
          end else begin
            ndir = w[CMD_DIR_BIT];
            cnt = q.reg_pulses;
          end
          if (kind == KIND_MODE_CTRL) begin
            if (w[CMD_CODE_LSB +: 16] == STOP_CODE) begin
              d.mode = M_IDLE;
              d.cur_f = ZERO32;
              d.stopping = 1'b0;
            end
          end else if (kind > KIND_FEED ||
                       !cmd_ok(q.mode, kind, cont, q.reg_freq == ZERO32)) begin
            d.cmd_err = 1'b1;
          end else if (kind == KIND_FEED && q.mode == M_FEED) begin
            d.stopping = 1'b1;
          end else begin
            d.stopping = 1'b0;
            d.tgt_f = q.reg_freq;
            if (q.mode == M_IDLE) begin
              d.dir = ndir;
              d.remaining = cnt;
              d.ramp_cnt = ZERO32;
              d.cur_f = ZERO32;
            end
            unique case (kind)
              KIND_SPEED: begin
                d.has_ramp = 1'b0;
                d.cur_f = q.reg_freq;
                d.mode = cont ? M_SPD_CONT : M_SPD_IND;
              end
              KIND_RAMPED: begin
                d.has_ramp = 1'b1;
                d.acc = q.reg_acc;
                d.dec = q.reg_dec;
                d.mode = cont ? M_ACC_CONT : M_ACC_IND;
              end
              KIND_POSITION: begin
                d.has_ramp = 1'b1;
                d.acc = q.reg_acc;
                d.dec = q.reg_dec;
                d.remaining = cnt;
                d.mode = M_POS;
              end
              KIND_ORIGIN: begin
                d.has_ramp = 1'b0;
                d.dir = 1'b1;
                d.cur_f = q.reg_freq;
                d.mode = M_ORG;
              end
              default: begin
                d.has_ramp = 1'b1;
                d.acc = q.reg_acc;
                d.dec = q.reg_dec;
                d.remaining = q.reg_pulses;
                d.feed_pos = 1'b0;
                d.mode = M_FEED;
              end
            endcase
          end
        end
        default: ;
      endcase
    end

    // Hardware sets win over software clears
    if (set_done) begin
      d.done = 1'b1;
    end
    if (set_stop) begin
      d.stop_err = 1'b1;
    end

    // Bus address phase and read data
    d.wr_pend = 1'b0;
    d.rd_pend = 1'b0;
    if (hsel && htrans[1] && hready) begin
      d.addr = {haddr[7:2], 2'b00};
      d.wr_pend = hwrite;
      d.rd_pend = !hwrite;
    end
    if (q.rd_pend) begin
      unique case (q.addr)
        FREQ_OFS: d.rdata = q.reg_freq;
        ACC_OFS: d.rdata = q.reg_acc;
        DEC_OFS: d.rdata = q.reg_dec;
        PULSES_OFS: d.rdata = q.reg_pulses;
        CFG_OFS: d.rdata = {30'h0, q.cfg};
        STATUS_OFS: d.rdata = {24'h0, q.feed_pos, q.feed_en, q.dir, q.origin_ok, q.stop_err,
                               q.cmd_err, q.done, q.mode != M_IDLE};
        PV_OFS: d.rdata = q.pv;
        ERR_OFS: d.rdata = {16'h0, q.err_code};
        CUR_FREQ_OFS: d.rdata = q.cur_f;
        RATIO_OFS: d.rdata = ratio_of(q.cur_f);
        default: d.rdata = ZERO32;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
      q.mode <= M_IDLE;
      q.cfg <= CFG_RESET;
      q.err_code <= ERR_NONE;
    end else begin
      q <= d;
    end
  end

  // Reads take one wait state so they see writes that just completed
  assign hreadyout = !q.rd_pend;
  assign hresp = 1'b0;
  assign hrdata = q.rdata;
  assign dir_ccw = q.dir;
  assign busy = (q.mode != M_IDLE);
endmodule : pcc_ctrl

// >>> pcc_pkg.sv
// Package for the pulse output command controller: map, fields, codes and timing
package pcc_pkg;
  // Register byte offsets
  localparam logic [7:0] CMD_OFS = 8'h00;
  localparam logic [7:0] FREQ_OFS = 8'h04;
  localparam logic [7:0] ACC_OFS = 8'h08;
  localparam logic [7:0] DEC_OFS = 8'h0c;
  localparam logic [7:0] PULSES_OFS = 8'h10;
  localparam logic [7:0] CFG_OFS = 8'h14;
  localparam logic [7:0] STATUS_OFS = 8'h18;
  localparam logic [7:0] PV_OFS = 8'h1c;
  localparam logic [7:0] ERR_OFS = 8'h20;
  localparam logic [7:0] CUR_FREQ_OFS = 8'h24;
  localparam logic [7:0] RATIO_OFS = 8'h28;
  // Command word fields
  localparam int CMD_KIND_LSB = 0;
  localparam int CMD_CONT_BIT = 3;
  localparam int CMD_ABS_BIT = 4;
  localparam int CMD_DIR_BIT = 5;
  localparam int CMD_CODE_LSB = 16;
  localparam logic [2:0] KIND_MODE_CTRL = 3'h0;
  localparam logic [2:0] KIND_SPEED = 3'h1;
  localparam logic [2:0] KIND_RAMPED = 3'h2;
  localparam logic [2:0] KIND_POSITION = 3'h3;
  localparam logic [2:0] KIND_ORIGIN = 3'h4;
  localparam logic [2:0] KIND_FEED = 3'h5;
  localparam logic [15:0] STOP_CODE = 16'h0003;
  // Configuration fields
  localparam int CFG_LIM_DECEL_BIT = 0;
  localparam int CFG_LIM_CLR_ORG_BIT = 1;
  localparam logic [1:0] CFG_RESET = 2'h0;
  // Status fields
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_DONE_BIT = 1;
  localparam int ST_CMD_ERR_BIT = 2;
  localparam int ST_STOP_ERR_BIT = 3;
  localparam int ST_ORIGIN_BIT = 4;
  localparam int ST_DIR_BIT = 5;
  localparam int ST_FEED_EN_BIT = 6;
  localparam int ST_FEED_POS_BIT = 7;
  // Stop error codes
  localparam logic [15:0] ERR_CW_LIMIT = 16'h0100;
  localparam logic [15:0] ERR_CCW_LIMIT = 16'h0101;
  localparam logic [15:0] ERR_NONE = 16'h0000;
  // Timing
  localparam longint CLK_HZ = 25000000;
  localparam longint RAMP_STEP_MS = 4;
  localparam longint RAMP_STEP_CYCLES = (CLK_HZ * RAMP_STEP_MS + 999) / 1000;
  localparam longint RAMP_STEPS_PER_S = 1000 / RAMP_STEP_MS;
  localparam logic [31:0] SRC_HZ = 32'(CLK_HZ);
  localparam logic [31:0] ZERO32 = 32'h0000_0000;

  typedef enum logic [2:0] {
    M_IDLE, M_SPD_IND, M_SPD_CONT, M_ACC_IND, M_ACC_CONT, M_POS, M_ORG, M_FEED
  } pcc_mode_e;
endpackage : pcc_pkg

// >>> pcc_pulse_gen.sv
// Integer-ratio pulse generator that drives the pulse pin and a tick per pulse
`timescale 1ns/1ps
module pcc_pulse_gen (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Division ratio, zero means no output
  input wire logic [31:0] ratio,
  // Pulse outputs
  output logic tick,
  output logic pulse_out
);
  import pcc_pkg::*;

  typedef struct packed {
    logic [31:0] cnt;
    logic tick;
    logic pulse;
  } pcc_gen_s;

  pcc_gen_s q, d;

  always_comb begin
    d = q;
    d.tick = 1'b0;
    if (ratio == ZERO32) begin
      // Parked at the top so the first pulse of a move also gives a tick
      d.cnt = '1;
      d.pulse = 1'b0;
    end else begin
      // Output period is exactly ratio clocks
      if (q.cnt >= ratio - 32'h1) begin
        d.cnt = ZERO32;
        d.tick = 1'b1;
      end else begin
        d.cnt = q.cnt + 32'h1;
      end
      d.pulse = (d.cnt < (ratio >> 1)) || (ratio == 32'h1);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign tick = q.tick;
  assign pulse_out = q.pulse;
endmodule : pcc_pulse_gen

// >>> pcc_motor.sv
// Motor drive model: counts step pulses, tracks position and pulse period
`timescale 1ns/1ps
module pcc_motor (
  // Clock
  input wire logic hclk,
  // Drive inputs
  input wire logic pulse_out,
  input wire logic dir_ccw,
  // Observed motion
  output int pos,
  output int cnt,
  output int period
);
  int t;
  int last;
  logic p_q = 1'b0;
  always @(posedge hclk) begin
    t <= t + 1;
    p_q <= pulse_out;
    if (pulse_out && !p_q) begin
      pos <= dir_ccw ? pos - 1 : pos + 1;
      cnt <= cnt + 1;
      period <= t - last;
      last <= t;
    end
  end
endmodule : pcc_motor

// >>> pcc_ctrl_asserts.sv
// Port-level assertions for the pulse output command controller
`timescale 1ns/1ps
module pcc_ctrl_asserts #(
  parameter logic [31:0] RAMP_CYCLES = 32'd100000
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // Sensors
  input wire logic cw_limit,
  input wire logic ccw_limit,
  input wire logic interrupt_input_zero,
  input wire logic origin_in,
  input wire logic feed_irq_enable_strap,
  // Drive
  input wire logic pulse_out,
  input wire logic dir_ccw,
  input wire logic busy
);
  import pcc_pkg::*;
  wire acc = hsel && htrans[1] && hready;
  logic wc_q;
  logic wf_q;
  logic rd_q;
  logic dec_q;
  // Data-phase markers and a shadow of the limit-deceleration choice
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wc_q <= 1'b0;
      wf_q <= 1'b0;
      rd_q <= 1'b0;
      dec_q <= 1'b0;
    end else begin
      wc_q <= acc && hwrite && haddr[7:2] == CMD_OFS[7:2];
      wf_q <= acc && hwrite && haddr[7:2] == CFG_OFS[7:2];
      rd_q <= acc && !hwrite;
      if (wf_q) begin
        dec_q <= hwdata[CFG_LIM_DECEL_BIT];
      end
    end
  end
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("bus response not okay");
  a_read_wait: assert property (acc && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  a_write_nowait: assert property (acc && hwrite |=> hreadyout)
    else $error("write was stretched");
  a_stop_now: assert property (
    wc_q && hwdata[2:0] == KIND_MODE_CTRL && hwdata[31:16] == STOP_CODE
    |-> ##[1:2] !busy ##1 (!pulse_out) [*4]) else $error("stop did not halt");
  a_cw_stop: assert property (
    $rose(cw_limit) && busy && !dec_q |-> ##[1:4] !busy) else $error("cw limit ignored");
  a_ccw_stop: assert property (
    $rose(ccw_limit) && busy && !dec_q |-> ##[1:4] !busy) else $error("ccw limit ignored");
  a_dir_cause: assert property (
    $changed(dir_ccw) |-> $past(wc_q) || $past(wc_q, 2)) else $error("direction moved alone");
  a_busy_cause: assert property (
    $rose(busy) |-> $past(wc_q) || $past(wc_q, 2)) else $error("motion without command");
  a_rdata_hold: assert property (
    $changed(hrdata) |-> $past(rd_q) || $past(rd_q, 2)) else $error("read data not held");
  c_stop: cover property (wc_q && hwdata[31:16] == STOP_CODE);
  c_cw: cover property ($rose(cw_limit) && busy);
  c_ccw: cover property ($rose(ccw_limit) && busy);
endmodule : pcc_ctrl_asserts

bind pcc_ctrl pcc_ctrl_asserts #(.RAMP_CYCLES(RAMP_CYCLES)) chk_u (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .cw_limit(cw_limit),
  .ccw_limit(ccw_limit), .interrupt_input_zero(interrupt_input_zero),
  .origin_in(origin_in), .feed_irq_enable_strap(feed_irq_enable_strap),
  .pulse_out(pulse_out), .dir_ccw(dir_ccw), .busy(busy));

// >>> pulse_output_command_control_tb.sv
// Self-checking bench for the pulse output command controller
`timescale 1ns/1ps
module pulse_output_command_control_tb;
  import pcc_pkg::*;
  logic hclk, hresetn, hsel, hwrite, cw_limit, ccw_limit, iz, origin_in, strap;
  logic [31:0] haddr, hwdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  wire hready, hresp, pulse_out, dir_ccw, busy;
  wire [31:0] hrdata;
  int pos, cnt, period, n_mismatch, checks_done, c, p, f;

  pcc_ctrl #(.RAMP_CYCLES(32'd20)) dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .cw_limit(cw_limit),
    .ccw_limit(ccw_limit), .interrupt_input_zero(iz), .origin_in(origin_in),
    .feed_irq_enable_strap(strap), .pulse_out(pulse_out), .dir_ccw(dir_ccw),
    .busy(busy));
  pcc_motor mot_u (.hclk(hclk), .pulse_out(pulse_out), .dir_ccw(dir_ccw),
    .pos(pos), .cnt(cnt), .period(period));

  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  function automatic logic [31:0] cmd(input logic [2:0] k, input logic ct,
      input logic ab, input logic dr);
    return {26'h0, dr, ab, ct, k};
  endfunction : cmd
  // Nearest-integer division ratio
  function automatic logic [31:0] rat(input int fr);
    return (SRC_HZ + 32'(fr / 2)) / 32'(fr);
  endfunction : rat

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0, a};
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask : bus
  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rdc
  task wait_idle;
    repeat (2) @(posedge hclk);
    for (int i = 0; i < 20000 && busy !== 1'b0; i++) @(posedge hclk);
    chk({31'h0, busy}, 32'h0);
  endtask : wait_idle
  task report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (60000) @(posedge hclk);
    n_mismatch++;
    report_and_stop;
  end

  initial begin
    hresetn = 1'b0;
    {hsel, hwrite, cw_limit, ccw_limit, iz, origin_in} = 6'h0;
    strap = 1'b1;
    htrans = 2'b00;
    haddr = 32'h0;
    hwdata = 32'h0;
    hsize = 3'h2;
    void'($urandom(32'h007954ac));
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    strap <= 1'b0;
    rdc(STATUS_OFS, 32'h40);
    wr(8'h40, 32'hffffffff);
    rdc(8'h40, 32'h0);
    rdc(CMD_OFS, 32'h0);
    // Continuous speed retargeted several times, first at a half-way ratio
    for (int i = 0; i < 4; i++) begin
      f = (i == 0) ? 400000 : 100000 + int'($urandom % 400000);
      wr(FREQ_OFS, f);
      wr(CMD_OFS, cmd(KIND_SPEED, 1'b1, 1'b0, 1'b0));
      rdc(RATIO_OFS, rat(f));
      rdc(CUR_FREQ_OFS, f);
      repeat (3 * rat(f) + 20) @(posedge hclk);
      chk(period, rat(f));
    end
    for (int k = 1; k < 6; k++) begin
      wr(CMD_OFS, cmd(3'(k), 1'b0, 1'b0, 1'b0));
      rdc(STATUS_OFS, 32'h45);
      wr(STATUS_OFS, 32'h4);
    end
    rdc(RATIO_OFS, rat(f));
    wr(CMD_OFS, {STOP_CODE, 16'h0});
    repeat (3) @(posedge hclk);
    chk({31'h0, busy}, 32'h0);
    c = cnt;
    repeat (300) @(posedge hclk);
    chk(cnt, c);
    wr(PULSES_OFS, 100);
    wr(FREQ_OFS, 1000000);
    wr(CMD_OFS, cmd(KIND_SPEED, 1'b0, 1'b0, 1'b0));
    repeat (500) @(posedge hclk);
    wr(PULSES_OFS, 400);
    wr(FREQ_OFS, 500000);
    wr(CMD_OFS, cmd(KIND_SPEED, 1'b0, 1'b0, 1'b0));
    rdc(STATUS_OFS, 32'h41);
    wait_idle;
    chk(cnt - c, 100);
    wr(ACC_OFS, 500000);
    wr(DEC_OFS, 500000);
    wr(PV_OFS, 0);
    // Absolute targets with the direction bit set against the true way
    for (int i = 0; i < 2; i++) begin
      p = pos;
      wr(PULSES_OFS, i ? 0 : -50);
      wr(CMD_OFS, cmd(KIND_POSITION, 1'b0, 1'b1, i[0]));
      wait_idle;
      chk({31'h0, dir_ccw}, {31'h0, !i[0]});
      chk(pos - p, i ? 50 : -50);
      rdc(STATUS_OFS, i ? 32'h42 : 32'h62);
      wr(STATUS_OFS, 32'h2);
    end
    rdc(PV_OFS, 32'h0);
    wr(CMD_OFS, cmd(KIND_ORIGIN, 1'b0, 1'b0, 1'b0));
    repeat (300) @(posedge hclk);
    origin_in <= 1'b1;
    wait_idle;
    origin_in <= 1'b0;
    for (int i = 0; i < 2; i++) begin
      wr(CFG_OFS, {30'h0, i[0], 1'b0});
      wr(CMD_OFS, cmd(KIND_SPEED, 1'b1, 1'b0, 1'b0));
      repeat (100) @(posedge hclk);
      if (i) ccw_limit <= 1'b1;
      else cw_limit <= 1'b1;
      wait_idle;
      rdc(ERR_OFS, {16'h0, i ? ERR_CCW_LIMIT : ERR_CW_LIMIT});
      bus(1'b0, STATUS_OFS, 32'h0);
      chk({30'h0, rd[4:3]}, {30'h0, !i[0], 1'b1});
      cw_limit <= 1'b0;
      ccw_limit <= 1'b0;
      wr(STATUS_OFS, 32'h8);
    end
    // Ramped continuous run, retarget, positioning takeover, limit with deceleration
    wr(ACC_OFS, 100000);
    wr(CMD_OFS, cmd(KIND_RAMPED, 1'b1, 1'b0, 1'b0));
    rdc(CUR_FREQ_OFS, 0);
    repeat (20) @(posedge hclk);
    rdc(CUR_FREQ_OFS, 100000);
    wr(FREQ_OFS, 300000);
    wr(CMD_OFS, cmd(KIND_RAMPED, 1'b1, 1'b0, 1'b0));
    repeat (200) @(posedge hclk);
    rdc(CUR_FREQ_OFS, 300000);
    wr(PULSES_OFS, 40);
    wr(FREQ_OFS, 250000);
    wr(CMD_OFS, cmd(KIND_POSITION, 1'b0, 1'b0, 1'b0));
    wait_idle;
    chk(period, rat(250000));
    rdc(STATUS_OFS, 32'h42);
    wr(STATUS_OFS, 32'h2);
    wr(CFG_OFS, 32'h1);
    wr(DEC_OFS, 50000);
    wr(CMD_OFS, cmd(KIND_RAMPED, 1'b1, 1'b0, 1'b0));
    repeat (100) @(posedge hclk);
    cw_limit <= 1'b1;
    repeat (3) @(posedge hclk);
    chk({31'h0, busy}, 32'h1);
    wait_idle;
    cw_limit <= 1'b0;
    wr(STATUS_OFS, 32'h8);
    wr(DEC_OFS, 500000);
    wr(FREQ_OFS, 500000);
    wr(PULSES_OFS, 30);
    wr(CMD_OFS, cmd(KIND_FEED, 1'b0, 1'b0, 1'b0));
    repeat (200) @(posedge hclk);
    wr(FREQ_OFS, 1000);
    wr(CMD_OFS, cmd(KIND_FEED, 1'b0, 1'b0, 1'b0));
    bus(1'b0, STATUS_OFS, 32'h0);
    chk({24'h0, rd[7:0]}, 32'h45);
    wr(STATUS_OFS, 32'h4);
    c = cnt;
    iz <= 1'b1;
    wait_idle;
    iz <= 1'b0;
    chk({31'h0, cnt - c >= 30 && cnt - c <= 31}, 32'h1);
    bus(1'b0, STATUS_OFS, 32'h0);
    chk({31'h0, rd[1]}, 32'h1);
    wr(STATUS_OFS, 32'h2);
    wr(FREQ_OFS, 500000);
    wr(CMD_OFS, cmd(KIND_FEED, 1'b0, 1'b0, 1'b0));
    repeat (200) @(posedge hclk);
    wr(FREQ_OFS, 0);
    wr(CMD_OFS, cmd(KIND_FEED, 1'b0, 1'b0, 1'b0));
    wait_idle;
    bus(1'b0, STATUS_OFS, 32'h0);
    chk({31'h0, rd[2]}, 32'h0);
    report_and_stop;
  end
endmodule : pulse_output_command_control_tb
